// *** include/tpm_consts.vh ***
// Overview of operation
// - Reset pin release leaves Off and reaches Idle within 10 to 25 ms.
// - Serial port is active in Idle; host controls device only through it.
// - Host requests Hibernate or Doze by a serial command issued in Idle.
// - Off while reset held: functions disabled, digital outputs and interrupt tri-stated.
// - Hibernate stops oscillator and serial port, keeps state, attention wakes in 7-20 ms.
// - Doze keeps oscillator; clock output only if enabled and at most 1 MHz.
// - Doze disables serial port; attention or timer match returns to Idle in 300us+period.
// - Idle runs the oscillator and offers the clock output pin.
// - Receive or Transmit entered within 144 us of leaving Idle, oscillator running.
// - Transmit power 0x00BC selects nominal, 0x00FF selects maximum output power.
// - Transactions are framed by active-low chip enable; device is slave only.
`ifndef TPM_CONSTS_VH
`define TPM_CONSTS_VH

// ==================================================
// Clock and timing
`define TPM_CLK_MHZ 125
`define TPM_OFF_WAKE_MS 10
`define TPM_OFF_WAKE_CYC (`TPM_OFF_WAKE_MS * 1000 * `TPM_CLK_MHZ)
`define TPM_HIB_WAKE_MS 7
`define TPM_HIB_WAKE_CYC (`TPM_HIB_WAKE_MS * 1000 * `TPM_CLK_MHZ)
`define TPM_DOZE_WAKE_US 300
`define TPM_DOZE_WAKE_CYC (`TPM_DOZE_WAKE_US * `TPM_CLK_MHZ)
`define TPM_RADIO_START_US 144
`define TPM_RADIO_START_CYC (`TPM_RADIO_START_US * `TPM_CLK_MHZ)

// ==================================================
// Register offsets
`define TPM_ADDR_MODE 8'h00
`define TPM_ADDR_CLOCK_OUTPUT_PIN_CFG 8'h04
`define TPM_ADDR_TX_POWER 8'h08
`define TPM_ADDR_TIMER_CMP 8'h0C
`define TPM_ADDR_TIMER 8'h10
`define TPM_ADDR_STATUS 8'h14

// ==================================================
// Mode commands, low three bits of the mode register
`define TPM_CMD_HIBERNATE 3'h1
`define TPM_CMD_DOZE 3'h2
`define TPM_CMD_RECEIVE 3'h3
`define TPM_CMD_TRANSMIT 3'h4
`define TPM_CMD_IDLE 3'h5

// ==================================================
// Fields and reset values
`define TPM_CLOCK_OUTPUT_PIN_EN_BIT 9
`define TPM_CLOCK_OUTPUT_PIN_SEL_MSB 2
`define TPM_CLOCK_OUTPUT_PIN_SEL_DOZE_MIN 3'h6
`define TPM_CLOCK_OUTPUT_PIN_SEL_RST 3'h7
`define TPM_CLOCK_OUTPUT_PIN_EN_RST 1'h0
`define TPM_TXPWR_NOMINAL 16'h00BC
`define TPM_TXPWR_MAX 16'h00FF
`define TPM_TXPWR_RST 16'h00BC
`define TPM_TIMER_CMP_RST 24'h00_0000

`endif

// *** design/tpm_clock_output_pin_div.v ***
`timescale 1ns/1ps
`include "tpm_consts.vh"
// ==================================================
// Clock output divider: output is the reference divided by 2^(sel+1)
module tpm_clock_output_pin_div (
   input wire clk,
   input wire rst,
   input wire run,
   input wire [2:0] sel,
   output wire clock_output_pin,
   output wire [8:0] period
);
   reg [7:0] cnt_reg;
   wire [7:0] cnt_next;

   // A stopped oscillator freezes the divider at zero, so the output is low
   assign cnt_next = run ? cnt_reg + 8'h01 : 8'h00;

   always @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign clock_output_pin = cnt_reg[sel];
   assign period = 9'h002 << sel;
endmodule // tpm_clock_output_pin_div

// *** design/tpm_power_mode.v ***
`timescale 1ns/1ps
`include "tpm_consts.vh"
// ==================================================
// Operational mode sequencer
module tpm_power_mode #(
   parameter [31:0] OFF_WAKE_CYC = `TPM_OFF_WAKE_CYC,
   parameter [31:0] HIB_WAKE_CYC = `TPM_HIB_WAKE_CYC,
   parameter [31:0] DOZE_WAKE_CYC = `TPM_DOZE_WAKE_CYC,
   parameter [31:0] RADIO_START_CYC = `TPM_RADIO_START_CYC
) (
   input wire REF_CLK,
   input wire SYS_RST,
   input wire RESET_PIN_N,
   input wire ATTENTION_WAKE_N,
   input wire CHIP_EN_N,
   input wire [7:0] REG_ADDR,
   input wire [31:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output wire [31:0] REG_RDATA,
   output wire [3:0] MODE_STATE,
   output wire OSC_EN,
   output wire SERIAL_ACTIVE,
   output wire RX_EN,
   output wire TX_EN,
   output wire [15:0] TX_POWER,
   output wire PA_NOMINAL,
   output wire PA_MAX,
   output wire CLOCK_OUTPUT_PIN,
   output wire CLOCK_OUTPUT_PIN_OE,
   output wire IRQ_N_OUT,
   output wire IRQ_N_OE
);
   // ==================================================
   // States
   localparam [3:0] ST_OFF = 4'h0;
   localparam [3:0] ST_WARMUP = 4'h1;
   localparam [3:0] ST_IDLE = 4'h2;
   localparam [3:0] ST_HIBERNATE = 4'h3;
   localparam [3:0] ST_HIB_WAKE = 4'h4;
   localparam [3:0] ST_DOZE = 4'h5;
   localparam [3:0] ST_DOZE_WAKE = 4'h6;
   localparam [3:0] ST_RX_START = 4'h7;
   localparam [3:0] ST_RX = 4'h8;
   localparam [3:0] ST_TX_START = 4'h9;
   localparam [3:0] ST_TX = 4'hA;

   // State that a finished countdown hands over to
   function [3:0] wait_done_state;
      input [3:0] s;
      begin
         case (s)
            ST_RX_START: wait_done_state = ST_RX;
            ST_TX_START: wait_done_state = ST_TX;
            default: wait_done_state = ST_IDLE;
         endcase
      end
   endfunction

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [31:0] wait_reg;
   reg [31:0] wait_next;
   reg clock_output_pin_en_reg;
   reg [2:0] clock_output_pin_sel_reg;
   reg [15:0] txpwr_reg;
   reg [23:0] tcmp_reg;
   reg [23:0] timer_reg;
   reg [31:0] rdata_reg;
   reg [31:0] rdata_next;
   reg osc_reg;
   reg serial_reg;
   reg rx_reg;
   reg tx_reg;
   reg clock_output_pin_oe_reg;
   reg clock_output_pin_oe_next;
   reg pin_oe_reg;
   reg clock_output_pin_pin_reg;

   wire reset_pin;
   wire attention_wake_input;
   wire serial_ok;
   wire bus_wr;
   wire bus_rd;
   wire cmd_wr;
   wire [2:0] cmd;
   wire timer_hit;
   wire clock_output_pin_doze_ok;
   wire osc_run;
   wire cfg_clear;
   wire div_clock_output_pin;
   wire [8:0] div_period;

   // ==================================================
   // Pin and bus qualification
   assign reset_pin = ~RESET_PIN_N;
   assign attention_wake_input = ~ATTENTION_WAKE_N;
   assign cfg_clear = SYS_RST | reset_pin;

   // Port only answers in modes where the core clock runs the register path
   assign serial_ok = (state_reg == ST_IDLE) || (state_reg == ST_RX_START) ||
                      (state_reg == ST_RX) || (state_reg == ST_TX_START) ||
                      (state_reg == ST_TX);

   // Accesses count only inside a chip enable frame
   assign bus_wr = REG_WR & ~CHIP_EN_N & serial_ok;
   assign bus_rd = REG_RD & ~CHIP_EN_N & serial_ok;

   assign cmd_wr = bus_wr && (REG_ADDR == `TPM_ADDR_MODE);
   assign cmd = REG_WDATA[2:0];
   assign timer_hit = (timer_reg == tcmp_reg);

   // Fast clock outputs would waste the doze current budget
   assign clock_output_pin_doze_ok = clock_output_pin_en_reg &&
                         (clock_output_pin_sel_reg >= `TPM_CLOCK_OUTPUT_PIN_SEL_DOZE_MIN);

   // Oscillator runs everywhere except Off and Hibernate
   assign osc_run = (state_reg != ST_OFF) && (state_reg != ST_HIBERNATE);

   // ==================================================
   // Clock output divider
   tpm_clock_output_pin_div u_clock_output_pin_div (
      .clk(REF_CLK),
      .rst(cfg_clear),
      .run(osc_run),
      .sel(clock_output_pin_sel_reg),
      .clock_output_pin(div_clock_output_pin),
      .period(div_period)
   );

   // ==================================================
   // Mode sequencer
   always @* begin
      state_next = state_reg;
      wait_next = wait_reg;
      if (reset_pin) begin
         state_next = ST_OFF;
         wait_next = 32'h0000_0000;
      end else begin
         case (state_reg)
            ST_OFF: begin
               state_next = ST_WARMUP;
               wait_next = OFF_WAKE_CYC;
            end
            ST_IDLE: begin
               if (cmd_wr) begin
                  case (cmd)
                     `TPM_CMD_HIBERNATE: state_next = ST_HIBERNATE;
                     `TPM_CMD_DOZE: state_next = ST_DOZE;
                     `TPM_CMD_RECEIVE: begin
                        state_next = ST_RX_START;
                        wait_next = RADIO_START_CYC;
                     end
                     `TPM_CMD_TRANSMIT: begin
                        state_next = ST_TX_START;
                        wait_next = RADIO_START_CYC;
                     end
                     default: state_next = ST_IDLE;
                  endcase
               end
            end
            ST_HIBERNATE: begin
               if (attention_wake_input) begin
                  state_next = ST_HIB_WAKE;
                  wait_next = HIB_WAKE_CYC;
               end
            end
            ST_DOZE: begin
               if (attention_wake_input || timer_hit) begin
                  state_next = ST_DOZE_WAKE;
                  wait_next = DOZE_WAKE_CYC + {23'h00_0000, div_period};
               end
            end
            ST_WARMUP, ST_HIB_WAKE, ST_DOZE_WAKE, ST_RX_START, ST_TX_START: begin
               if (wait_reg <= 32'h0000_0001) begin
                  state_next = wait_done_state(state_reg);
               end else begin
                  wait_next = wait_reg - 32'h0000_0001;
               end
            end
            ST_RX, ST_TX: begin
               if (cmd_wr && (cmd == `TPM_CMD_IDLE)) begin
                  state_next = ST_IDLE;
               end
            end
            default: begin
               state_next = ST_OFF;
            end
         endcase
      end
   end

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         state_reg <= ST_OFF;
         wait_reg <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         wait_reg <= wait_next;
      end
   end

   // ==================================================
   // Clock output enable for the next mode
   always @* begin
      case (state_next)
         ST_IDLE, ST_RX_START, ST_RX, ST_TX_START, ST_TX: begin
            clock_output_pin_oe_next = 1'b1;
         end
         ST_DOZE, ST_DOZE_WAKE: begin
            clock_output_pin_oe_next = clock_output_pin_doze_ok;
         end
         default: begin
            clock_output_pin_oe_next = 1'b0;
         end
      endcase
   end

   // ==================================================
   // Mode outputs, registered so they change with the state
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         osc_reg <= 1'b0;
         serial_reg <= 1'b0;
         rx_reg <= 1'b0;
         tx_reg <= 1'b0;
         clock_output_pin_oe_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
         clock_output_pin_pin_reg <= 1'b0;
      end else begin
         osc_reg <= (state_next != ST_OFF) && (state_next != ST_HIBERNATE);
         serial_reg <= (state_next == ST_IDLE) || (state_next == ST_RX_START) ||
                       (state_next == ST_RX) || (state_next == ST_TX_START) ||
                       (state_next == ST_TX);
         rx_reg <= (state_next == ST_RX);
         tx_reg <= (state_next == ST_TX);
         clock_output_pin_oe_reg <= clock_output_pin_oe_next;
         pin_oe_reg <= (state_next != ST_OFF);
         clock_output_pin_pin_reg <= clock_output_pin_oe_next & div_clock_output_pin;
      end
   end

   // ==================================================
   // Configuration; kept through Hibernate, cleared only by a reset
   always @(posedge REF_CLK) begin
      if (cfg_clear) begin
         clock_output_pin_en_reg <= `TPM_CLOCK_OUTPUT_PIN_EN_RST;
         clock_output_pin_sel_reg <= `TPM_CLOCK_OUTPUT_PIN_SEL_RST;
         txpwr_reg <= `TPM_TXPWR_RST;
         tcmp_reg <= `TPM_TIMER_CMP_RST;
      end else if (bus_wr) begin
         case (REG_ADDR)
            `TPM_ADDR_CLOCK_OUTPUT_PIN_CFG: begin
               clock_output_pin_en_reg <= REG_WDATA[`TPM_CLOCK_OUTPUT_PIN_EN_BIT];
               clock_output_pin_sel_reg <= REG_WDATA[`TPM_CLOCK_OUTPUT_PIN_SEL_MSB:0];
            end
            `TPM_ADDR_TX_POWER: begin
               txpwr_reg <= REG_WDATA[15:0];
            end
            `TPM_ADDR_TIMER_CMP: begin
               tcmp_reg <= REG_WDATA[23:0];
            end
            default: begin
               tcmp_reg <= tcmp_reg;
            end
         endcase
      end
   end

   // ==================================================
   // Wake timer; it stops with the oscillator
   always @(posedge REF_CLK) begin
      if (cfg_clear) begin
         timer_reg <= 24'h00_0000;
      end else if (osc_run) begin
         timer_reg <= timer_reg + 24'h00_0001;
      end
   end

   // ==================================================
   // Read port; data stand for one cycle, zero otherwise
   always @* begin
      rdata_next = 32'h0000_0000;
      if (bus_rd) begin
         case (REG_ADDR)
            `TPM_ADDR_MODE: begin
               rdata_next = {28'h000_0000, state_reg};
            end
            `TPM_ADDR_CLOCK_OUTPUT_PIN_CFG: begin
               rdata_next = {22'h00_0000, clock_output_pin_en_reg, 6'h00, clock_output_pin_sel_reg};
            end
            `TPM_ADDR_TX_POWER: begin
               rdata_next = {16'h0000, txpwr_reg};
            end
            `TPM_ADDR_TIMER_CMP: begin
               rdata_next = {8'h00, tcmp_reg};
            end
            `TPM_ADDR_TIMER: begin
               rdata_next = {8'h00, timer_reg};
            end
            `TPM_ADDR_STATUS: begin
               rdata_next = {26'h000_0000, osc_reg, clock_output_pin_oe_reg, rx_reg, tx_reg,
                             PA_MAX, PA_NOMINAL};
            end
            default: begin
               rdata_next = 32'h0000_0000;
            end
         endcase
      end
   end

   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ==================================================
   // Outputs
   assign REG_RDATA = rdata_reg;
   assign MODE_STATE = state_reg;
   assign OSC_EN = osc_reg;
   assign SERIAL_ACTIVE = serial_reg;
   assign RX_EN = rx_reg;
   assign TX_EN = tx_reg;
   assign TX_POWER = txpwr_reg;
   assign PA_NOMINAL = (txpwr_reg == `TPM_TXPWR_NOMINAL);
   assign PA_MAX = (txpwr_reg == `TPM_TXPWR_MAX);
   assign CLOCK_OUTPUT_PIN = clock_output_pin_pin_reg;
   assign CLOCK_OUTPUT_PIN_OE = clock_output_pin_oe_reg;
   // No interrupt source lives here; the line idles high and floats in Off
   assign IRQ_N_OUT = 1'b1;
   assign IRQ_N_OE = pin_oe_reg;
endmodule // tpm_power_mode

// *** dv/tpm_host_pins.sv ***
`timescale 1ns/1ps
// ==================================================
// Host side of the reset and attention pins
module tpm_host_pins (
   input wire clk,
   output reg reset_pin_n,
   output reg attention_wake_input_n
);
   initial begin
      reset_pin_n = 1'b1;
      attention_wake_input_n = 1'b1;
   end
   // Low for 32 cycles of 8 ns, so never shorter than 250 ns
   task hold_reset;
      begin
         @(posedge clk) reset_pin_n <= 1'b0;
         repeat (32) @(posedge clk);
         reset_pin_n <= 1'b1;
      end
   endtask
   // A single low cycle is enough since the pin is sampled as a level
   task wake;
      begin
         @(posedge clk) attention_wake_input_n <= 1'b0;
         @(posedge clk) attention_wake_input_n <= 1'b1;
      end
   endtask
endmodule // tpm_host_pins

// *** dv/tpm_power_mode_assertions.sv ***
`timescale 1ns/1ps
module tpm_power_mode_assertions #(
   parameter [31:0] OFF_WAKE_CYC = 32'h0000_0014,
   parameter [31:0] HIB_WAKE_CYC = 32'h0000_000F,
   parameter [31:0] RADIO_START_CYC = 32'h0000_0008
) (
   input wire REF_CLK,
   input wire SYS_RST,
   input wire RESET_PIN_N,
   input wire ATTENTION_WAKE_N,
   input wire CHIP_EN_N,
   input wire [7:0] REG_ADDR,
   input wire REG_RD,
   input wire [31:0] REG_RDATA,
   input wire [3:0] MODE_STATE,
   input wire OSC_EN,
   input wire SERIAL_ACTIVE,
   input wire RX_EN,
   input wire TX_EN,
   input wire [15:0] TX_POWER,
   input wire PA_NOMINAL,
   input wire PA_MAX,
   input wire CLOCK_OUTPUT_PIN,
   input wire CLOCK_OUTPUT_PIN_OE,
   input wire IRQ_N_OE
);
   localparam [31:0] SLACK = 32'h0000_0002;
   reg [3:0] last_reg;
   reg [31:0] stay_reg;
   // ==================================================
   // Cycles spent in the state just left, sampled on the exit edge
   always @(posedge REF_CLK) begin
      if (SYS_RST) begin
         last_reg <= 4'h0;
         stay_reg <= 32'h0000_0000;
      end else begin
         last_reg <= MODE_STATE;
         stay_reg <= (MODE_STATE != last_reg) ? 32'h0000_0001 : stay_reg + 32'h0000_0001;
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   AST_OFF_PIN: assert property (!RESET_PIN_N |=> MODE_STATE == 4'h0)
      else $error("reset pin did not force Off");
   AST_OFF_HIZ: assert property (MODE_STATE == 4'h0 |-> !IRQ_N_OE && !CLOCK_OUTPUT_PIN_OE)
      else $error("output driven in Off");
   AST_CLOCK_OUTPUT_PIN_QUIET: assert property (!CLOCK_OUTPUT_PIN_OE |-> !CLOCK_OUTPUT_PIN)
      else $error("clock output toggles while released");
   AST_OSC: assert property (OSC_EN == (MODE_STATE != 4'h0 && MODE_STATE != 4'h3))
      else $error("oscillator enable wrong for mode");
   AST_PORT: assert property (SERIAL_ACTIVE == (MODE_STATE == 4'h2 || MODE_STATE > 4'h6))
      else $error("serial port availability wrong");
   AST_RADIO: assert property (RX_EN == (MODE_STATE == 4'h8) && TX_EN == (MODE_STATE == 4'hA))
      else $error("radio enable wrong for mode");
   AST_PA: assert property (PA_MAX == (TX_POWER == 16'h00FF) && PA_NOMINAL == (TX_POWER == 16'h00BC))
      else $error("power level flags wrong");
   AST_READ: assert property (REG_RD && !CHIP_EN_N && REG_ADDR == 8'h00 && SERIAL_ACTIVE
      |=> REG_RDATA == {28'h000_0000, $past(MODE_STATE)})
      else $error("mode read wrong");
   AST_DEAF: assert property (REG_RD && (MODE_STATE == 4'h3 || MODE_STATE == 4'h5)
      |=> REG_RDATA == 32'h0000_0000)
      else $error("read answered while port disabled");
   AST_HIB_HOLD: assert property (MODE_STATE == 4'h3 && ATTENTION_WAKE_N && RESET_PIN_N
      |=> MODE_STATE == 4'h3)
      else $error("left Hibernate without attention");
   AST_WARM_TIME: assert property (last_reg == 4'h1 && MODE_STATE == 4'h2
      |-> stay_reg + SLACK >= OFF_WAKE_CYC && stay_reg <= OFF_WAKE_CYC + SLACK)
      else $error("warm-up length wrong");
   AST_HIB_TIME: assert property (last_reg == 4'h4 && MODE_STATE == 4'h2
      |-> stay_reg + SLACK >= HIB_WAKE_CYC && stay_reg <= HIB_WAKE_CYC + SLACK)
      else $error("hibernate wake length wrong");
   AST_RF_TIME: assert property ((last_reg == 4'h7 || last_reg == 4'h9) && MODE_STATE != last_reg
      |-> stay_reg + SLACK >= RADIO_START_CYC && stay_reg <= RADIO_START_CYC)
      else $error("radio start length wrong");
   COV_DOZE_WAKE: cover property (last_reg == 4'h6 && MODE_STATE == 4'h2);
   COV_HIB_WAKE: cover property (last_reg == 4'h4 && MODE_STATE == 4'h2);
   COV_TX: cover property (last_reg == 4'h9 && MODE_STATE == 4'hA);
endmodule // tpm_power_mode_assertions

// *** dv/tpm_power_mode_tb.sv ***
`timescale 1ns/1ps
module tpm_power_mode_tb;
   localparam [31:0] OFFW = 32'h0000_0014;
   localparam [31:0] HIBW = 32'h0000_000F;
   localparam [31:0] DOZW = 32'h0000_000A;
   localparam [31:0] RADW = 32'h0000_0008;
   reg REF_CLK = 1'b0;
   reg SYS_RST = 1'b1;
   reg CHIP_EN_N = 1'b1;
   reg [7:0] REG_ADDR = 8'h00;
   reg [31:0] REG_WDATA = 32'h0000_0000;
   reg REG_WR = 1'b0;
   reg REG_RD = 1'b0;
   wire RESET_PIN_N, ATTENTION_WAKE_N, OSC_EN, SERIAL_ACTIVE, RX_EN, TX_EN, PA_NOMINAL, PA_MAX;
   wire CLOCK_OUTPUT_PIN, CLOCK_OUTPUT_PIN_OE, IRQ_N_OUT, IRQ_N_OE;
   wire [31:0] REG_RDATA;
   wire [3:0] MODE_STATE;
   wire [15:0] TX_POWER;
   integer bad_count = 0;
   integer cmp_count = 0;
   integer n;
   integer i;
   reg [31:0] d;
   always #4 REF_CLK = ~REF_CLK;
   tpm_host_pins host (.clk(REF_CLK), .reset_pin_n(RESET_PIN_N), .attention_wake_input_n(ATTENTION_WAKE_N));
   tpm_power_mode #(.OFF_WAKE_CYC(OFFW), .HIB_WAKE_CYC(HIBW), .DOZE_WAKE_CYC(DOZW),
      .RADIO_START_CYC(RADW)) uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
      .RESET_PIN_N(RESET_PIN_N), .ATTENTION_WAKE_N(ATTENTION_WAKE_N), .CHIP_EN_N(CHIP_EN_N),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .MODE_STATE(MODE_STATE), .OSC_EN(OSC_EN),
      .SERIAL_ACTIVE(SERIAL_ACTIVE), .RX_EN(RX_EN), .TX_EN(TX_EN), .TX_POWER(TX_POWER),
      .PA_NOMINAL(PA_NOMINAL), .PA_MAX(PA_MAX), .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN),
      .CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE(IRQ_N_OE));
   task print_verdict;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
         if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task chk_win(input integer lo, input integer hi);
      begin
         cmp_count = cmp_count + 1;
         if (n < lo || n > hi) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got %h exp %h..%h", $time, n, lo, hi);
         end
      end
   endtask
   // ==================================================
   // Bus cycles; chip enable frames each read strobe, and each write strobe when ce_n is low
   task wr(input [7:0] a, input [31:0] v, input ce_n);
      begin
         @(posedge REF_CLK);
         CHIP_EN_N <= ce_n;
         REG_ADDR <= a;
         REG_WDATA <= v;
         REG_WR <= 1'b1;
         @(posedge REF_CLK);
         REG_WR <= 1'b0;
         CHIP_EN_N <= 1'b1;
         #1;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge REF_CLK);
         CHIP_EN_N <= 1'b0;
         REG_ADDR <= a;
         REG_RD <= 1'b1;
         @(posedge REF_CLK);
         REG_RD <= 1'b0;
         CHIP_EN_N <= 1'b1;
         #1 d = REG_RDATA;
      end
   endtask
   task wait_mode(input [3:0] s, input integer lim);
      begin
         n = 0;
         while (MODE_STATE !== s && n < lim) begin
            @(posedge REF_CLK);
            #1 n = n + 1;
         end
         if (MODE_STATE !== s) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t got %h exp %h", $time, MODE_STATE, s);
            print_verdict;
         end
      end
   endtask
   // ==================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      wait_mode(4'h2, 40);
      chk_win(OFFW, OFFW + 3);
      rd(8'h00);
      chk(d, 32'h0000_0002);
      rd(8'h08);
      chk(d, 32'h0000_00BC);
      rd(8'h04);
      chk(d, 32'h0000_0007);
      rd(8'h3C);
      chk(d, 32'h0000_0000);
      // Idle drives the clock output at the reset divide: 128 cycles per half period
      n = 0;
      d[0] = CLOCK_OUTPUT_PIN;
      for (i = 0; i < 256; i = i + 1) begin
         @(posedge REF_CLK);
         #1 n = n + (CLOCK_OUTPUT_PIN !== d[0]);
         d[0] = CLOCK_OUTPUT_PIN;
      end
      chk(n, 32'h0000_0002);
      wr(8'h08, 32'h0000_00FF, 1'b0);
      chk({14'h0000, TX_POWER, PA_MAX, PA_NOMINAL}, 32'h0000_03FE);
      wr(8'h08, 32'h0000_0033, 1'b1);
      rd(8'h08);
      chk(d, 32'h0000_00FF);
      wr(8'h08, 32'h0000_00BC, 1'b0);
      chk({14'h0000, TX_POWER, PA_MAX, PA_NOMINAL}, 32'h0000_02F1);
      // Divide by 128 keeps the clock output under 1 MHz, so it stays driven in Doze
      wr(8'h04, 32'h0000_0206, 1'b0);
      wr(8'h00, 32'h0000_0002, 1'b0);
      chk({28'h000_0000, MODE_STATE}, 32'h0000_0005);
      chk({29'h0000_0000, OSC_EN, CLOCK_OUTPUT_PIN_OE, SERIAL_ACTIVE}, 32'h0000_0006);
      wr(8'h08, 32'h0000_0011, 1'b0);
      rd(8'h08);
      chk(d, 32'h0000_0000);
      host.wake;
      wait_mode(4'h2, 200);
      chk_win(DOZW + 127, DOZW + 131);
      rd(8'h08);
      chk(d, 32'h0000_00BC);
      wr(8'h04, 32'h0000_0205, 1'b0);
      rd(8'h10);
      wr(8'h0C, (d + 32'h0000_0030) & 32'h00FF_FFFF, 1'b0);
      wr(8'h00, 32'h0000_0002, 1'b0);
      chk({31'h0000_0000, CLOCK_OUTPUT_PIN_OE}, 32'h0000_0000);
      wait_mode(4'h2, 200);
      chk_win(DOZW + 98, DOZW + 116);
      wr(8'h00, 32'h0000_0001, 1'b0);
      chk({27'h000_0000, MODE_STATE, OSC_EN}, 32'h0000_0006);
      wr(8'h08, 32'h0000_0022, 1'b0);
      repeat (20) @(posedge REF_CLK);
      #1 chk({28'h000_0000, MODE_STATE}, 32'h0000_0003);
      host.wake;
      wait_mode(4'h2, 40);
      chk_win(HIBW, HIBW + 3);
      rd(8'h08);
      chk(d, 32'h0000_00BC);
      for (i = 0; i < 2; i = i + 1) begin
         wr(8'h00, 32'h0000_0003 + i, 1'b0);
         wait_mode(i[0] ? 4'hA : 4'h8, 20);
         chk_win(RADW - 1, RADW);
         chk({29'h0000_0000, TX_EN, RX_EN, OSC_EN}, 32'h0000_0003 + 2 * i);
         wr(8'h00, 32'h0000_0005, 1'b0);
         wait_mode(4'h2, 4);
      end
      wr(8'h08, 32'h0000_00FF, 1'b0);
      host.hold_reset;
      #1 d = {25'h000_0000, MODE_STATE, IRQ_N_OE, CLOCK_OUTPUT_PIN_OE, IRQ_N_OUT};
      chk(d, 32'h0000_0001);
      wait_mode(4'h2, 40);
      chk_win(OFFW, OFFW + 3);
      rd(8'h08);
      chk(d, 32'h0000_00BC);
      rd(8'h14);
      chk(d, 32'h0000_0031);
      rd(8'h0C);
      chk(d, 32'h0000_0000);
      print_verdict;
   end
endmodule // tpm_power_mode_tb
bind tpm_power_mode tpm_power_mode_assertions #(.OFF_WAKE_CYC(OFF_WAKE_CYC),
   .HIB_WAKE_CYC(HIB_WAKE_CYC), .RADIO_START_CYC(RADIO_START_CYC)) u_chk (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .RESET_PIN_N(RESET_PIN_N),
   .ATTENTION_WAKE_N(ATTENTION_WAKE_N), .CHIP_EN_N(CHIP_EN_N), .REG_ADDR(REG_ADDR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MODE_STATE(MODE_STATE), .OSC_EN(OSC_EN),
   .SERIAL_ACTIVE(SERIAL_ACTIVE), .RX_EN(RX_EN), .TX_EN(TX_EN), .TX_POWER(TX_POWER),
   .PA_NOMINAL(PA_NOMINAL), .PA_MAX(PA_MAX), .CLOCK_OUTPUT_PIN(CLOCK_OUTPUT_PIN),
   .CLOCK_OUTPUT_PIN_OE(CLOCK_OUTPUT_PIN_OE),
   .IRQ_N_OE(IRQ_N_OE));
